// ### common/pfc_pkg.sv
// constants and carrier types for the parallel flash command host
// assumes one 40 MHz clock and pin drivers outside that switch supply levels
package pfc_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_SETUP_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;

    // ------------------------------------------------------------
    // data bus layout
    // ------------------------------------------------------------
    localparam logic [15:0] DQ_WORD_MASK = 16'hFFFF;
    localparam logic [15:0] DQ_BYTE_MASK = 16'h80FF;
    localparam logic [15:0] DQ_ADDR_ONLY = 16'h8000;
    localparam int MSB_DQ_POS = 15;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int WE_PULSE_NS = 50;
    localparam int READ_ACCESS_NS = 80;
    localparam int RP_LOW_NS = 100;
    localparam int RP_RECOVER_NS = 300;
    localparam int ENGINE_WAIT_US = 1000;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_LOW_CYC = (RP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_RECOVER_CYC = (RP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENGINE_WAIT_CYC = (ENGINE_WAIT_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ,
        OP_READ_ARRAY,
        OP_PROGRAM,
        OP_ERASE,
        OP_READ_ID
    } pfc_op_t;

    typedef struct packed {
        pfc_op_t op;
        logic [19:0] addr;
        logic [15:0] data;
        logic byte_mode;
        logic boot;
        logic unlock_vhh;
        logic id_sel;
    } pfc_req_t;

    typedef struct packed {
        logic write;
        logic [15:0] data;
        logic last;
    } pfc_cyc_t;

endpackage : pfc_pkg

// ### src/pfc_bus_cycle.sv
// one asynchronous bus cycle on the flash pins, write or read
// assumes the caller holds its inputs while start_i is high for one cycle
`timescale 1ns/1ps
module pfc_bus_cycle
    import pfc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // request
    input wire logic start_i,
    input wire logic write_i,
    input wire logic byte_mode_i,
    input wire logic [19:0] addr_i,
    input wire logic [15:0] wdata_i,
    // answer
    output logic done_o,
    output logic [15:0] rdata_o,
    // flash pins
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [18:0] addr_o,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_o,
    input wire logic [15:0] dq_i
);

    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} pfc_bstate_t;

    pfc_bstate_t state_q;
    logic write_q;
    logic byte_q;
    logic [2:0] cnt_q;
    logic [2:0] strobe_end;

    assign strobe_end = write_q ? 3'(WE_PULSE_CYC - 1) : 3'(READ_ACCESS_CYC - 1);

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= B_IDLE;
            write_q <= 1'b0;
            byte_q <= 1'b0;
            cnt_q <= 3'h0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            addr_o <= 19'h00000;
            dq_o <= 16'h0000;
            dq_oe_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            case (state_q)
                B_IDLE: begin
                    if (start_i) begin
                        write_q <= write_i;
                        byte_q <= byte_mode_i;
                        ce_n_o <= 1'b0; // RULE13
                        addr_o <= addr_i[19:1];
                        dq_o <= byte_mode_i ? {addr_i[0], 7'h00, wdata_i[7:0]} : wdata_i;
                        if (write_i) begin
                            dq_oe_o <= byte_mode_i ? DQ_BYTE_MASK : DQ_WORD_MASK; // RULE12
                        end else begin
                            dq_oe_o <= byte_mode_i ? DQ_ADDR_ONLY : 16'h0000; // RULE11
                        end
                        state_q <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    if (write_q) begin
                        we_n_o <= 1'b0; // RULE13
                    end else begin
                        oe_n_o <= 1'b0;
                    end
                    cnt_q <= 3'h0;
                    state_q <= B_STROBE;
                end
                B_STROBE: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == strobe_end) begin
                        we_n_o <= 1'b1; // RULE13
                        oe_n_o <= 1'b1;
                        if (!write_q) begin
                            rdata_o <= byte_q ? {8'h00, dq_i[7:0]} : dq_i; // RULE6 RULE7
                        end
                        state_q <= B_HOLD;
                    end
                end
                B_HOLD: begin
                    ce_n_o <= 1'b1;
                    dq_oe_o <= 16'h0000;
                    done_o <= 1'b1;
                    state_q <= B_IDLE;
                end
                default: begin
                    state_q <= B_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_read_no_drive: assert property (!oe_n_o |-> dq_oe_o[14:0] == 15'h0000) // RULE11
        else $error("data driven while output enable low");
    a_we_pulse_len: assert property ($fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o) // RULE13
        else $error("write strobe width wrong");
    a_strobe_data_hold: assert property ($rose(we_n_o) // RULE13
        |-> dq_oe_o[0] && !ce_n_o && oe_n_o)
        else $error("data or select dropped at strobe end");
    a_read_access_len: assert property ($fell(oe_n_o) |-> !oe_n_o [*4] ##1 oe_n_o) // RULE11
        else $error("read access width wrong");

endmodule : pfc_bus_cycle

// ### src/pfc_host.sv
// host controller that drives a block-erasable parallel flash through its pins
// assumes external switches turn the supply flags into real voltages
`timescale 1ns/1ps
// Summary of operation
// RULE1: erase is setup 20h then confirm D0h, supply raised before confirm.
// RULE2: program is setup 40h then address and data write with supply high.
// RULE3: read-array FFh is written before any array read after program or erase.
// RULE4: boot block changes need reset pin at unlock voltage or unlock pin high.
// RULE5: id read: id line at id voltage, other upper lines low, select picks code.
// RULE6: word-wide id reads return the upper byte as well.
// RULE7: byte-wide id reads use only the low eight data lines.
// RULE8: erase touches only the addressed block, so its address goes with both writes.
// RULE9: the flash engine finishes alone; the host only waits.
// RULE10: reset pin low clears the flash and floats all of its pins.
// RULE11: flash drives data only with output enable low; host floats then. In byte mode the host keeps driving line 15.
// RULE12: byte mode floats lines 8 to 14 and line 15 carries the lowest address.
// RULE13: value set with select low, output enable high, latched at strobe end.
module pfc_host
    import pfc_pkg::*;
#(
    parameter int unsigned ENGINE_WAIT = ENGINE_WAIT_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // user request
    input wire logic req_valid_i,
    input wire pfc_req_t req_i,
    output logic busy_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    // flash control pins
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic byte_n_o,
    output logic reset_powerdown_n_o,
    output logic boot_unlock_o,
    // flash supply switches
    output logic program_supply_high_o,
    output logic unlock_high_voltage_o,
    output logic id_high_voltage_o,
    // flash address and data
    output logic [18:0] addr_o,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_o,
    input wire logic [15:0] dq_i
);

    typedef enum logic [2:0] {
        M_RESET, M_RECOVER, M_IDLE, M_ISSUE, M_BUS, M_ENGINE
    } pfc_mstate_t;

    // ------------------------------------------------------------
    // step decode
    // ------------------------------------------------------------
    function automatic pfc_cyc_t pfc_step(pfc_op_t op, logic step, logic [15:0] data,
                                          logic array_mode);
        pfc_cyc_t c;
        c = '{write: 1'b0, data: 16'h0000, last: 1'b1};
        case (op)
            OP_ERASE: begin
                c.write = 1'b1;
                c.data = {8'h00, step ? CMD_ERASE_CONFIRM : CMD_ERASE_SETUP};
                c.last = step;
            end
            OP_PROGRAM: begin
                c.write = 1'b1;
                c.data = step ? data : {8'h00, CMD_PROGRAM_SETUP};
                c.last = step;
            end
            OP_READ_ARRAY: begin
                c.write = 1'b1;
                c.data = {8'h00, CMD_READ_ARRAY};
            end
            OP_READ: begin
                if (!array_mode && !step) begin
                    c.write = 1'b1;
                    c.data = {8'h00, CMD_READ_ARRAY};
                    c.last = 1'b0;
                end
            end
            default: begin
                c.write = 1'b0;
            end
        endcase
        return c;
    endfunction : pfc_step

    function automatic logic pfc_is_change(pfc_op_t op);
        return (op == OP_ERASE) || (op == OP_PROGRAM);
    endfunction : pfc_is_change

    pfc_mstate_t state_q;
    pfc_req_t req_q;
    pfc_cyc_t cyc_q;
    logic step_q;
    logic start_q;
    logic array_mode_q;
    logic [31:0] wait_q;
    logic bus_done;
    logic [15:0] bus_rdata;
    logic [19:0] bus_addr;

    // id reads force every upper address line low, select on the lowest word line
    assign bus_addr = (req_q.op == OP_READ_ID) ? {18'h00000, req_q.id_sel, 1'b0}
                                               : req_q.addr; // RULE5 RULE8

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= M_RESET;
            req_q <= '0;
            cyc_q <= '0;
            step_q <= 1'b0;
            start_q <= 1'b0;
            wait_q <= 32'(RP_LOW_CYC);
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            start_q <= 1'b0;
            done_o <= 1'b0;
            case (state_q)
                M_RESET: begin
                    wait_q <= wait_q - 32'h1;
                    if (wait_q <= 32'h1) begin
                        wait_q <= 32'(RP_RECOVER_CYC);
                        state_q <= M_RECOVER;
                    end
                end
                M_RECOVER: begin
                    wait_q <= wait_q - 32'h1;
                    if (wait_q <= 32'h1) begin
                        busy_o <= 1'b0;
                        state_q <= M_IDLE;
                    end
                end
                M_IDLE: begin
                    if (req_valid_i) begin
                        req_q <= req_i;
                        step_q <= 1'b0;
                        busy_o <= 1'b1;
                        state_q <= M_ISSUE;
                    end
                end
                M_ISSUE: begin
                    cyc_q <= pfc_step(req_q.op, step_q, req_q.data, array_mode_q);
                    start_q <= 1'b1;
                    state_q <= M_BUS;
                end
                M_BUS: begin
                    if (bus_done) begin
                        if (!cyc_q.last) begin
                            step_q <= 1'b1;
                            state_q <= M_ISSUE;
                        end else if (pfc_is_change(req_q.op)) begin
                            wait_q <= ENGINE_WAIT; // RULE9
                            state_q <= M_ENGINE;
                        end else begin
                            done_o <= 1'b1;
                            busy_o <= 1'b0;
                            state_q <= M_IDLE;
                        end
                    end
                end
                M_ENGINE: begin
                    wait_q <= wait_q - 32'h1; // RULE9
                    if (wait_q <= 32'h1) begin
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state_q <= M_IDLE;
                    end
                end
                default: begin
                    state_q <= M_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read mode tracking and read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            array_mode_q <= 1'b1;
            rdata_o <= 16'h0000;
        end else if (state_q == M_BUS && bus_done) begin
            if (cyc_q.write && cyc_q.data[7:0] == CMD_READ_ARRAY && !pfc_is_change(req_q.op)) begin
                array_mode_q <= 1'b1; // RULE3
            end else if (pfc_is_change(req_q.op)) begin
                array_mode_q <= 1'b0; // RULE3
            end
            if (!cyc_q.write) begin
                rdata_o <= bus_rdata; // RULE6 RULE7
            end
        end
    end

    // ------------------------------------------------------------
    // supply and strap levels
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            reset_powerdown_n_o <= 1'b0; // RULE10
            program_supply_high_o <= 1'b0;
            unlock_high_voltage_o <= 1'b0;
            boot_unlock_o <= 1'b0;
            id_high_voltage_o <= 1'b0;
            byte_n_o <= 1'b1;
        end else if (state_q != M_IDLE) begin
            reset_powerdown_n_o <= (state_q != M_RESET); // RULE10
        end else begin
            reset_powerdown_n_o <= 1'b1;
            if (req_valid_i) begin
                program_supply_high_o <= pfc_is_change(req_i.op); // RULE1 RULE2
                unlock_high_voltage_o <= pfc_is_change(req_i.op) && req_i.boot
                                         && req_i.unlock_vhh; // RULE4
                boot_unlock_o <= pfc_is_change(req_i.op) && req_i.boot
                                 && !req_i.unlock_vhh; // RULE4
                id_high_voltage_o <= (req_i.op == OP_READ_ID); // RULE5
                byte_n_o <= !req_i.byte_mode; // RULE12
            end else begin
                program_supply_high_o <= 1'b0;
                unlock_high_voltage_o <= 1'b0;
                boot_unlock_o <= 1'b0;
                id_high_voltage_o <= 1'b0;
            end
        end
    end

    pfc_bus_cycle u_bus (
        .mclk_i(mclk_i),
        .reset_i(reset_i || state_q == M_RESET),
        .start_i(start_q),
        .write_i(cyc_q.write),
        .byte_mode_i(req_q.byte_mode),
        .addr_i(bus_addr),
        .wdata_i(cyc_q.data),
        .done_o(bus_done),
        .rdata_o(bus_rdata),
        .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o),
        .we_n_o(we_n_o),
        .addr_o(addr_o),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o),
        .dq_i(dq_i)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_erase_confirm_vpp: assert property (start_q && req_q.op == OP_ERASE && step_q
        |-> program_supply_high_o && cyc_q.data[7:0] == CMD_ERASE_CONFIRM) // RULE1
        else $error("erase confirm without supply or wrong code");
    a_erase_setup_first: assert property (start_q && req_q.op == OP_ERASE && !step_q
        |-> cyc_q.write && cyc_q.data[7:0] == CMD_ERASE_SETUP) // RULE1
        else $error("erase not opened by setup code");
    a_program_data_vpp: assert property (start_q && req_q.op == OP_PROGRAM && step_q
        |-> program_supply_high_o && cyc_q.data == req_q.data) // RULE2
        else $error("program data written without supply");
    a_array_before_read: assert property (start_q && !cyc_q.write && req_q.op == OP_READ
        |-> array_mode_q) // RULE3
        else $error("array read without read-array command");
    a_boot_unlocked: assert property (start_q && req_q.boot && pfc_is_change(req_q.op) && step_q
        |-> boot_unlock_o || unlock_high_voltage_o) // RULE4
        else $error("boot block change while locked");
    a_id_address_low: assert property (start_q && req_q.op == OP_READ_ID
        |-> id_high_voltage_o ##[1:3] (!ce_n_o && addr_o[18:1] == 18'h00000)) // RULE5
        else $error("id read with upper address lines high");
    a_reset_float: assert property (!reset_powerdown_n_o // RULE10
        |-> dq_oe_o == 16'h0000 && ce_n_o)
        else $error("pins driven while flash in reset");
    a_byte_mode_float: assert property (!byte_n_o |-> dq_oe_o[14:8] == 7'h00) // RULE12
        else $error("upper data lines driven in byte mode");
    a_engine_hold_vpp: assert property (state_q == M_ENGINE && pfc_is_change(req_q.op)
        |-> program_supply_high_o) // RULE9
        else $error("supply dropped while engine busy");

endmodule : pfc_host

// ### testbench/pfc_flash_model.sv
// behavioural flash device on the far side of the host controller
// assumes the bench resolves the shared data lines and feeds them back on dq_i
`timescale 1ns/1ps
module pfc_flash_model #(
    parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h5A3C, // arbitrary value
    parameter int ENGINE_NS = 100
) (
    // control pins
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic byte_n_i,
    input wire logic reset_powerdown_n_i,
    input wire logic boot_unlock_i,
    // supply levels
    input wire logic program_supply_high_i,
    input wire logic unlock_high_voltage_i,
    input wire logic id_high_voltage_i,
    // address and data
    input wire logic [18:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic [15:0] dq_drv_o,
    output logic fault_o
);
    // ----
    // state
    // ----
    logic [15:0] mem [logic [18:0]];
    logic array_q = 1'b1;
    logic erase_q = 1'b0;
    logic prog_q = 1'b0;
    logic id_ok;
    logic [15:0] rd, w;
    time busy_until = 0;

    function automatic logic [3:0] blk_of(input logic [18:0] a);
        if (a < 19'h02000) return 4'h0;
        if (a < 19'h03000) return 4'h1;
        if (a < 19'h04000) return 4'h2;
        if (a < 19'h10000) return 4'h3;
        return {1'b0, a[18:16]} + 4'h3;
    endfunction : blk_of

    wire ok_w = program_supply_high_i && (blk_of(addr_i) != 4'h0 || unlock_high_voltage_i
        || boot_unlock_i);

    // ----
    // command decoder and write engine
    // ----
    initial fault_o = 1'b0;
    always @(negedge reset_powerdown_n_i) begin
        array_q = 1'b1;
        erase_q = 1'b0;
        prog_q = 1'b0;
    end
    always @(negedge program_supply_high_i) begin
        if ($time < busy_until) fault_o = 1'b1;
    end
    always @(posedge we_n_i) begin
        if (reset_powerdown_n_i && !ce_n_i && oe_n_i) begin
            if (prog_q) begin
                w = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
                if (byte_n_i) w = dq_i;
                else if (dq_i[15]) w[15:8] = dq_i[7:0];
                else w[7:0] = dq_i[7:0];
                if (ok_w) mem[addr_i] = w;
                if (ok_w) busy_until = $time + ENGINE_NS;
                prog_q = 1'b0;
                array_q = 1'b0;
            end else if (erase_q) begin
                if (dq_i[7:0] == 8'hD0 && ok_w) begin
                    foreach (mem[k]) if (blk_of(k) == blk_of(addr_i)) mem[k] = 16'hFFFF;
                    busy_until = $time + ENGINE_NS;
                end
                erase_q = 1'b0;
                array_q = 1'b0;
            end else begin
                erase_q = (dq_i[7:0] == 8'h20);
                prog_q = (dq_i[7:0] == 8'h40 || dq_i[7:0] == 8'h10);
                array_q = (dq_i[7:0] == 8'hFF);
            end
        end
    end

    // ----
    // read path
    // ----
    always @* begin
        id_ok = id_high_voltage_i && addr_i[8:1] == 8'h00 && addr_i[17:10] == 8'h00;
        rd = id_ok ? (addr_i[0] ? DEV_CODE : MFR_CODE) : !array_q ? 16'h0080
            : mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
        if (!byte_n_i) rd = {8'h00, (dq_i[15] && !id_ok) ? rd[15:8] : rd[7:0]};
        dq_o = rd;
        dq_drv_o = 16'h0000;
        if (reset_powerdown_n_i && !ce_n_i && !oe_n_i && we_n_i)
            dq_drv_o = byte_n_i ? 16'hFFFF : 16'h00FF;
    end
endmodule : pfc_flash_model

// ### testbench/test_pfc_host.sv
// self-checking bench for the flash host controller against a flash model
// assumes pfc_pkg is compiled first
`timescale 1ns/1ps
module test_pfc_host;
    import pfc_pkg::*;
    localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
    localparam logic [15:0] DEV = 16'h5A3C; // arbitrary value
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    pfc_req_t req_i = '0;
    logic busy, done, ce_n, oe_n, we_n, byte_n, rp_n, unl, vpp, unlock_high_voltage, id_high_voltage, fault;
    logic [15:0] rdata, host_dq, dq_oe, dq_bus, fl_dq, fl_drv, rd, exp_v;
    logic [15:0] dq_last = 16'h0000;
    logic [18:0] addr;
    logic [15:0] ref_mem [logic [18:0]];
    logic [19:0] a_q [$];
    logic [31:0] r;
    int seed = 32'h33BA;
    int fail_count = 0;
    int checks_done = 0;

    always #12.5 mclk_i = ~mclk_i;

    pfc_host #(.ENGINE_WAIT(20)) u_pfc_host (.mclk_i(mclk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy), .done_o(done),
        .rdata_o(rdata), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .byte_n_o(byte_n),
        .reset_powerdown_n_o(rp_n), .boot_unlock_o(unl), .program_supply_high_o(vpp),
        .unlock_high_voltage_o(unlock_high_voltage), .id_high_voltage_o(id_high_voltage), .addr_o(addr), .dq_o(host_dq),
        .dq_oe_o(dq_oe), .dq_i(dq_bus));
    pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_pfc_flash_model (
        .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .byte_n_i(byte_n),
        .reset_powerdown_n_i(rp_n), .boot_unlock_i(unl), .program_supply_high_i(vpp),
        .unlock_high_voltage_i(unlock_high_voltage), .id_high_voltage_i(id_high_voltage), .addr_i(addr), .dq_i(dq_bus),
        .dq_o(fl_dq), .dq_drv_o(fl_drv), .fault_o(fault));

    // ----
    // shared data lines, undriven bits toggle
    // ----
    always @* for (int i = 0; i < 16; i++)
        dq_bus[i] = dq_oe[i] ? host_dq[i] : fl_drv[i] ? fl_dq[i] : ~dq_last[i];
    always @(posedge mclk_i) dq_last <= dq_bus;
    always @(posedge mclk_i) begin
        if (!reset_i && oe_n === 1'b0) check("host_dq_oe", dq_oe, {!byte_n, 15'h0});
        if (!reset_i && we_n === 1'b0) check("strobe_state", {14'h0, ce_n, oe_n}, 16'h0001);
    end

    // ----
    // helpers
    // ----
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    function automatic logic [3:0] blk(input logic [18:0] a);
        return a < 19'h02000 ? 4'h0 : a < 19'h03000 ? 4'h1 : a < 19'h04000 ? 4'h2
            : a < 19'h10000 ? 4'h3 : {1'b0, a[18:16]} + 4'h3;
    endfunction : blk

    function automatic logic [15:0] ref_rd(input logic [19:0] a, input logic bm);
        logic [15:0] w;
        w = ref_mem.exists(a[19:1]) ? ref_mem[a[19:1]] : 16'hFFFF;
        return bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    endfunction : ref_rd

    task automatic issue(input pfc_op_t op, input logic [19:0] a, input logic [15:0] d,
                         input logic bm, input logic bt, input logic vh, input logic sel);
        for (int n = 0; busy !== 1'b0 && n < 400; n++) @(posedge mclk_i) #2;
        req_i = '{op: op, addr: a, data: d, byte_mode: bm, boot: bt, unlock_vhh: vh, id_sel: sel};
        req_valid_i = 1'b1;
        @(posedge mclk_i);
        #2;
        req_valid_i = 1'b0;
    endtask : issue

    task automatic run_op(input pfc_op_t op, input logic [19:0] a, input logic [15:0] d,
                          input logic bm, input logic bt, input logic vh, input logic sel);
        issue(op, a, d, bm, bt, vh, sel);
        for (int n = 0; done !== 1'b1 && n < 400; n++) @(posedge mclk_i) #2;
        check("done_pulse", {15'h0, done}, 16'h0001);
        rd = rdata;
    endtask : run_op

    task automatic prog(input logic [19:0] a, input logic [15:0] d, input logic bm,
                        input logic vh);
        logic [15:0] w;
        run_op(OP_PROGRAM, a, d, bm, blk(a[19:1]) == 4'h0, vh, 1'b0);
        w = ref_mem.exists(a[19:1]) ? ref_mem[a[19:1]] : 16'hFFFF;
        if (!bm) w = d;
        else if (a[0]) w[15:8] = d[7:0];
        else w[7:0] = d[7:0];
        ref_mem[a[19:1]] = w;
        a_q.push_back(a);
    endtask : prog

    task automatic erase_blk(input logic [19:0] a, input logic vh);
        run_op(OP_ERASE, a, 16'h0000, 1'b0, blk(a[19:1]) == 4'h0, vh, 1'b0);
        foreach (ref_mem[k]) if (blk(k) == blk(a[19:1])) ref_mem[k] = 16'hFFFF;
    endtask : erase_blk

    task automatic read_all;
        foreach (a_q[i]) begin
            run_op(OP_READ, a_q[i], 16'h0000, a_q[i][0], 1'b0, 1'b0, 1'b0);
            check("array_read", rd, ref_rd(a_q[i], a_q[i][0]));
        end
    endtask : read_all

    // ----
    // main sequence
    // ----
    initial begin
        repeat (4) @(posedge mclk_i) #2;
        check("rp_in_reset", {15'h0, rp_n}, 16'h0000);
        reset_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            run_op(OP_READ_ID, 20'h00000, 16'h0000, i[1], 1'b0, 1'b0, i[0]);
            exp_v = i[0] ? DEV : MFR;
            if (i[1]) exp_v = {8'h00, exp_v[7:0]};
            check("id_code", rd, exp_v);
        end
        for (int i = 0; i < 10; i++) begin
            r = $random(seed);
            prog({r[18:16] == 3'h0 ? 3'h1 : r[18:16], r[15:0], r[20] & r[21]}, r[31:16], r[21],
                 1'b0);
        end
        prog(20'h24000, 16'h1234, 1'b0, 1'b0);
        prog(20'h30002, 16'h5678, 1'b0, 1'b0);
        prog(20'h04001, 16'h009A, 1'b1, 1'b0);
        prog(20'h00010, 16'hBEEF, 1'b0, 1'b1);
        prog(20'h02021, 16'h00C3, 1'b1, 1'b0);
        read_all();
        erase_blk(20'h20010, 1'b0);
        erase_blk(20'h00000, 1'b0);
        run_op(OP_READ_ARRAY, 20'h00000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
        read_all();
        issue(OP_PROGRAM, 20'h50000, 16'h4321, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (22) @(posedge mclk_i) #2;
        reset_i = 1'b1;
        repeat (2) @(posedge mclk_i) #2;
        check("reset_pins", {rp_n, vpp, ce_n, we_n, 12'h0}, 16'h3000);
        check("reset_dq_oe", dq_oe, 16'h0000);
        reset_i = 1'b0;
        run_op(OP_READ, 20'h24000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
        check("read_after_reset", rd, ref_rd(20'h24000, 1'b0));
        check("supply_held", {15'h0, fault}, 16'h0000);
        end_of_test();
    end

    initial begin
        #(25 * 40000);
        fail_count++;
        end_of_test();
    end
endmodule : test_pfc_host
